//--- dv/caq_inst_model.sv
`timescale 1ns/10ps
module caq_inst_model (
  // Live instrument outputs
  output caq_pkg::caq_samples_t samples,
  // Rear trigger pin
  output logic rear_trigger_input
);
  import caq_pkg::*;
  // Fixed per-channel values so stored curves are predictable
  initial begin
    rear_trigger_input = 1'b0;
    for (int k = 0; k < 21; k++) begin
      samples.ch[k] = 16'h0100 + 16'(k);
    end
  end
  // one clean edge, off the clock
  task automatic pulse();
    #37 rear_trigger_input = 1'b1;
    #400 rear_trigger_input = 1'b0;
  endtask : pulse
endmodule : caq_inst_model

//--- dv/tb.sv
`timescale 1ns/10ps
`include "caq_regs.svh"
module tb;
  import caq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic dual_mode = 1'b0;
  logic tc_ge_5ms = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fast_tc_640;
  logic [1:0] bresp, rresp, resp_q;
  logic [31:0] rdata, rd_q;
  caq_samples_t samples;
  logic rear_trigger_input;
  int n_mismatch = 0;
  int checked = 0;
  always #50 aclk = ~aclk;
  // Short tick keeps the run small; figures scale with it
  caq_ctrl #(.TICK_CYC(40), .FAST_CYC(25)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .samples(samples), .dual_mode(dual_mode), .tc_ge_5ms(tc_ge_5ms),
    .rear_trigger_input(rear_trigger_input), .fast_tc_640(fast_tc_640)
  );
  caq_inst_model u_inst (
    .samples(samples), .rear_trigger_input(rear_trigger_input)
  );
  task automatic test_done();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // A wait that runs out ends the run as a failure
  task automatic tick(inout int k);
    @(posedge aclk);
    k++;
    if (k > 60) begin
      n_mismatch++;
      test_done();
    end
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    int k;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(k);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do tick(k); while (!bvalid);
    resp_q = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(k); while (!arready);
    arvalid <= 1'b0;
    do tick(k); while (!rvalid);
    rd_q = rdata;
    resp_q = rresp;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] v);
    rd(a);
    cmp(rd_q & m, v);
  endtask : chk
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((rd_q & m) !== v && n < 400);
    cmp(rd_q & m, v);
  endtask : poll
  task automatic dump(input logic [31:0] c, input logic [31:0] v);
    wr(`CAQ_A_DUMP, c);
    // exactly one curve length of reads
    for (int k = 0; k < 2; k++) begin
      poll(`CAQ_A_SBYTE, 32'h0000_0080, 32'h0000_0080);
      chk(`CAQ_A_DDATA, 32'hFFFF_FFFF, v);
    end
    chk(`CAQ_A_SBYTE, 32'h0000_0002, 32'h0000_0002);
  endtask : dump
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(`CAQ_A_SEL, ALL, 32'h0000_0003);
    chk(`CAQ_A_LEN, ALL, 32'h0000_0100);
    chk(`CAQ_A_INTV, ALL, 32'h0000_0005);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0000);
    rd(8'h30);
    cmp(32'(resp_q), 32'(`CAQ_RESP_ERR));
    wr(8'h30, 32'h0000_0001);
    cmp(32'(resp_q), 32'(`CAQ_RESP_ERR));
    wr(`CAQ_A_LEN, 32'h0000_4001);
    chk(`CAQ_A_SBYTE, 32'h0000_0004, 32'h0000_0004);
    chk(`CAQ_A_LEN, ALL, 32'h0000_0100);
    wr(`CAQ_A_LEN, 32'h0000_4000);
    chk(`CAQ_A_LEN, ALL, 32'h0000_4000);
    wr(`CAQ_A_SEL, 32'h0000_0007);
    chk(`CAQ_A_LEN, ALL, 32'h0000_2AAA);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    wr(`CAQ_A_SEL, 32'h0000_2001);
    wr(`CAQ_A_LEN, 32'h0000_0002);
    wr(`CAQ_A_EVENT, 32'h0000_1234);
    wr(`CAQ_A_CTRL, 32'h0000_0002);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0001);
    poll(`CAQ_A_STAT, ALL, 32'h0000_0000);
    chk(`CAQ_A_SWEEP, ALL, 32'h0000_0001);
    chk(`CAQ_A_POINTS, ALL, 32'h0000_0002);
    dump(32'h0000_000D, 32'h0000_1234);
    dump(32'h0000_0000, 32'h0000_0100);
    wr(`CAQ_A_DUMP, 32'h0000_0100);
    chk(`CAQ_A_SBYTE, 32'h0000_0004, 32'h0000_0004);
    chk(`CAQ_A_SBYTE, 32'h0000_0001, 32'h0000_0001);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    wr(`CAQ_A_CTRL, 32'h0000_0008);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0002);
    wr(`CAQ_A_CTRL, 32'h0000_0010);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0006);
    wr(`CAQ_A_CTRL, 32'h0000_0008);
    poll(`CAQ_A_SWEEP, ALL, 32'h0000_0001);
    wr(`CAQ_A_CTRL, 32'h0000_0010);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0006);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0000);
    chk(`CAQ_A_SWEEP, ALL, 32'h0000_0000);
    chk(`CAQ_A_POINTS, ALL, 32'h0000_0000);
    wr(`CAQ_A_CTRL, 32'h0000_0002);
    wr(`CAQ_A_CTRL, 32'h0000_0010);
    chk(`CAQ_A_STAT, ALL, 32'h0000_0005);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    wr(`CAQ_A_TMODE, 32'h0000_0001);
    wr(`CAQ_A_CTRL, 32'h0000_0004);
    // Trigger spacing shrunk in step with the tick
    for (int k = 0; k < 2; k++) begin
      u_inst.pulse();
      repeat (100) @(posedge aclk);
    end
    chk(`CAQ_A_POINTS, ALL, 32'h0000_0002);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    wr(`CAQ_A_TMODE, 32'h0000_0000);
    wr(`CAQ_A_CTRL, 32'h0000_0004);
    repeat (200) @(posedge aclk);
    chk(`CAQ_A_POINTS, ALL, 32'h0000_0000);
    u_inst.pulse();
    @(posedge aclk);
    poll(`CAQ_A_POINTS, ALL, 32'h0000_0002);
    wr(`CAQ_A_CTRL, 32'h0000_0001);
    tc_ge_5ms <= 1'b1;
    wr(`CAQ_A_INTV, 32'h0000_0000);
    wr(`CAQ_A_SEL, 32'h0000_0001);
    wr(`CAQ_A_CTRL, 32'h0000_0002);
    repeat (3) @(posedge aclk);
    cmp(32'(fast_tc_640), 32'h0000_0001);
    poll(`CAQ_A_STAT, ALL, 32'h0000_0000);
    chk(`CAQ_A_POINTS, ALL, 32'h0000_0002);
    chk(`CAQ_A_SEL, ALL, 32'h0000_0003);
    wr(`CAQ_A_SEL, 32'h0001_0001);
    chk(`CAQ_A_SBYTE, 32'h0000_0004, 32'h0000_0004);
    dual_mode <= 1'b1;
    wr(`CAQ_A_SEL, 32'h0001_0001);
    chk(`CAQ_A_SEL, ALL, 32'h0001_0001);
    test_done();
  end
endmodule : tb

//--- hw/caq_ctrl.sv
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "caq_regs.svh"
// What this block does, and what its host must do
// R01 - Refuse too long length, flag error
// R02 - Length times curves fits 32768 points
// R03 - Host sends smaller selection before longer length
// R04 - New curve clears state and counters
// R05 - Interval in ms, rounded up to 5
// R06 - Zero interval stores every 1.25 ms
// R07 - Fast mode forces X and Y selection
// R08 - Fast mode long constant uses 640 us
// R09 - Single take stops when buffer full
// R10 - Whole-curve trigger takes full curve set
// R11 - Point trigger stores one point each
// R12 - Continuous take wraps until halted
// R13 - Bit 13 stores event marker value
// R14 - Halt suspends, take commands resume
// R15 - Status code 0, 1, 2, 5, 6
// R16 - Sweep counter counts completed buffers
// R17 - Point counter counts stored points
// R18 - Monitor values in fixed order
// R19 - Dump one selected curve by bit
// R20 - Float dump needs sensitivity curve stored
// R21 - Fixed point dump sends stored values
// R22 - Ready bit 7, end bit 1
// R23 - Host reads exactly length values
// R24 - Whole mode is 0, waits edge
// R25 - Interval timer strobes while running
module caq_ctrl #(
  parameter int TICK_CYC = `CAQ_TICK_CYC,
  parameter int FAST_CYC = `CAQ_FAST_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instrument side
  input wire caq_pkg::caq_samples_t samples,
  input wire logic dual_mode,
  input wire logic tc_ge_5ms,
  input wire logic rear_trigger_input,
  output logic fast_tc_640
);
  import caq_pkg::*;

  caq_ctl_t c_q;
  caq_ctl_t c_d;
  caq_axi_t x_q;
  caq_axi_t x_d;
  logic [15:0] mem [`CAQ_BUF_PTS];
  logic [15:0] mem_rd_q;
  logic mem_we;
  logic [14:0] mem_wa;
  logic [15:0] mem_wd;
  logic rear_trigger_input_s1_q;
  logic rear_trigger_input_s2_q;
  logic rear_trigger_input_s3_q;
  logic rear_trigger_input_edge;
  logic wr_go;
  logic wr_en;
  logic rd_en;
  logic pop;
  logic [7:0] wr_addr;
  logic [31:0] wd;
  logic [31:0] rd_word;
  logic [31:0] sel_x;
  logic [31:0] fmask_x;
  logic strobe;
  logic pt_done;
  logic running;
  logic fast;
  logic [29:0] acc_n;
  logic [4:0] dn;
  logic [15:0] period;

  function automatic logic [4:0] caq_popcnt(input logic [20:0] v);
    caq_popcnt = 5'h00;
    for (int i = 0; i < 21; i++) begin
      caq_popcnt = caq_popcnt + {4'h0, v[i]};
    end
  endfunction : caq_popcnt

  function automatic logic [4:0] caq_rank(input logic [20:0] v,
                                          input logic [4:0] n);
    caq_rank = 5'h00;
    for (int i = 0; i < 21; i++) begin
      if (i < int'(n)) begin
        caq_rank = caq_rank + {4'h0, v[i]};
      end
    end
  endfunction : caq_rank

  function automatic logic caq_fits(input logic [15:0] len,
                                    input logic [4:0] n);
    logic [20:0] p;
    p = 21'(len) * 21'(n);
    caq_fits = (p <= `CAQ_BUF_PTS);
  endfunction : caq_fits

  function automatic logic [14:0] caq_addr(input logic [4:0] slot,
                                           input logic [15:0] len,
                                           input logic [15:0] pos);
    logic [20:0] a;
    a = 21'(slot) * 21'(len) + 21'(pos);
    caq_addr = a[14:0];
  endfunction : caq_addr

  function automatic logic caq_mapped(input logic [7:0] a);
    caq_mapped = (a[1:0] == 2'h0) && (a <= `CAQ_A_DDATA);
  endfunction : caq_mapped

  // Trigger pin is asynchronous, so two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rear_trigger_input_s1_q <= 1'b0;
      rear_trigger_input_s2_q <= 1'b0;
      rear_trigger_input_s3_q <= 1'b0;
    end else begin
      rear_trigger_input_s1_q <= rear_trigger_input;
      rear_trigger_input_s2_q <= rear_trigger_input_s1_q;
      rear_trigger_input_s3_q <= rear_trigger_input_s2_q;
    end
  end
  assign rear_trigger_input_edge = rear_trigger_input_s2_q & ~rear_trigger_input_s3_q;

  assign wr_go = x_q.aw_hold & x_q.w_hold & ~x_q.bvalid;
  assign wr_en = wr_go & (x_q.wstrb == 4'hF);
  assign wr_addr = x_q.awaddr;
  assign wd = x_q.wdata;
  assign rd_en = s_axi_arvalid & x_q.arready;
  assign pop = rd_en && (s_axi_araddr == `CAQ_A_DDATA) && c_q.dready;
  assign sel_x = {11'h000, c_q.sel};
  assign fmask_x = `CAQ_FLOAT_MASK;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `CAQ_A_SEL: rd_word = sel_x;
      `CAQ_A_LEN: rd_word = {16'h0000, c_q.len};
      `CAQ_A_INTV: rd_word = {2'h0, c_q.intv};
      `CAQ_A_TMODE: rd_word = {31'h0000_0000, c_q.tmode};
      `CAQ_A_EVENT: rd_word = {17'h0_0000, c_q.evt};
      // R15 triggered runs report as single
      `CAQ_A_STAT: begin
        if (c_q.st == CAQ_REAR_TRIGGER_INPUT_WAIT || c_q.st == CAQ_REAR_TRIGGER_INPUT_RUN) begin
          rd_word = 32'h0000_0001;
        end else begin
          rd_word = {29'h0000_0000, c_q.st};
        end
      end
      // R18 monitor words in order
      `CAQ_A_SWEEP: rd_word = c_q.sweep;
      `CAQ_A_SBYTE: rd_word = {24'h00_0000, c_q.sbyte};
      `CAQ_A_POINTS: rd_word = c_q.points;
      `CAQ_A_DUMP: rd_word = {15'h0000, c_q.dact, c_q.didx};
      // R21 raw stored value
      `CAQ_A_DDATA: rd_word = {{16{c_q.ddata[15]}}, c_q.ddata};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    x_d = x_q;
    if (s_axi_awvalid && x_q.awready) begin
      x_d.aw_hold = 1'b1;
      x_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && x_q.wready) begin
      x_d.w_hold = 1'b1;
      x_d.wdata = s_axi_wdata;
      x_d.wstrb = s_axi_wstrb;
    end
    if (x_q.bvalid && s_axi_bready) begin
      x_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      x_d.aw_hold = 1'b0;
      x_d.w_hold = 1'b0;
      x_d.bvalid = 1'b1;
      x_d.bresp = caq_mapped(x_q.awaddr) ? `CAQ_RESP_OK : `CAQ_RESP_ERR;
    end
    x_d.awready = ~x_d.aw_hold;
    x_d.wready = ~x_d.w_hold;
    if (x_q.rvalid && s_axi_rready) begin
      x_d.rvalid = 1'b0;
    end
    if (rd_en) begin
      x_d.rvalid = 1'b1;
      x_d.rdata = rd_word;
      x_d.rresp = caq_mapped(s_axi_araddr) ? `CAQ_RESP_OK : `CAQ_RESP_ERR;
    end
    x_d.arready = ~x_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_q <= '0;
    end else begin
      x_q <= x_d;
    end
  end

  always_comb begin
    c_d = c_q;
    strobe = 1'b0;
    pt_done = 1'b0;
    mem_we = 1'b0;
    mem_wa = 15'h0000;
    mem_wd = 16'h0000;
    dn = wd[4:0];
    acc_n = c_q.acc + `CAQ_STEP_MS;
    fast = (c_q.intv == 30'h0000_0000);
    period = fast ? 16'(FAST_CYC - 1) : 16'(TICK_CYC - 1);
    running = (c_q.st == CAQ_SINGLE) || (c_q.st == CAQ_CONT) ||
              (c_q.st == CAQ_REAR_TRIGGER_INPUT_RUN);
    // R16 query clears sweeps
    // R17 query clears points
    if (rd_en && (s_axi_araddr == `CAQ_A_SEL ||
                  s_axi_araddr == `CAQ_A_LEN)) begin
      c_d.sweep = 32'h0000_0000;
      c_d.points = 32'h0000_0000;
    end
    // R25 interval timer strobe
    if (!running) begin
      c_d.tick = 16'h0000;
      c_d.acc = 30'h0000_0000;
    end else if (c_q.tick == period) begin
      c_d.tick = 16'h0000;
      // R06 fast rate strobe
      if (fast) begin
        strobe = 1'b1;
      // R05 rounds up to 5 ms
      end else if (acc_n >= c_q.intv) begin
        strobe = 1'b1;
        c_d.acc = 30'h0000_0000;
      end else begin
        c_d.acc = acc_n;
      end
    end else begin
      c_d.tick = c_q.tick + 16'h0001;
    end
    // R24 wait for edge
    if (c_q.st == CAQ_REAR_TRIGGER_INPUT_WAIT && rear_trigger_input_edge) begin
      // R11 one point per edge
      if (c_q.tmode) begin
        strobe = ~c_q.wbusy;
      // R10 whole curve per edge
      end else begin
        c_d.st = CAQ_REAR_TRIGGER_INPUT_RUN;
      end
    end
    if (strobe && !c_q.wbusy) begin
      c_d.wbusy = 1'b1;
      c_d.wbit = 5'h00;
      c_d.wslot = 5'h00;
      c_d.snap = samples;
    end
    // Sweeps one channel a cycle; far shorter than any interval
    if (c_q.wbusy) begin
      if (c_q.sel[c_q.wbit]) begin
        mem_we = 1'b1;
        mem_wa = caq_addr(c_q.wslot, c_q.len, c_q.pos);
        mem_wd = c_q.snap.ch[c_q.wbit];
        // R13 event marker stored
        if (c_q.wbit == `CAQ_EVENT_BIT) begin
          mem_wd = {1'b0, c_q.evt};
        end
        c_d.wslot = c_q.wslot + 5'h01;
      end
      if (c_q.wbit == `CAQ_LAST_BIT) begin
        c_d.wbusy = 1'b0;
        pt_done = 1'b1;
      end else begin
        c_d.wbit = c_q.wbit + 5'h01;
      end
    end
    if (pt_done) begin
      // R17 count stored points
      c_d.points = c_d.points + 32'h0000_0001;
      if (17'(c_q.pos) + 17'h0_0001 >= 17'(c_q.len)) begin
        // R12 continuous wraps round
        c_d.pos = 16'h0000;
        // R16 count full sweeps
        c_d.sweep = c_d.sweep + 32'h0000_0001;
        // R09 single stops full
        if (c_q.st == CAQ_SINGLE) begin
          c_d.st = CAQ_IDLE;
        end
        if (c_q.st == CAQ_REAR_TRIGGER_INPUT_RUN) begin
          c_d.st = CAQ_REAR_TRIGGER_INPUT_WAIT;
        end
      end else begin
        c_d.pos = c_q.pos + 16'h0001;
      end
    end
    c_d.dfetch = c_q.dact && !c_q.dready && !c_q.dfetch;
    if (c_q.dfetch) begin
      c_d.ddata = mem_rd_q;
      c_d.dready = 1'b1;
    end
    if (wr_en) begin
      c_d.sbyte[`CAQ_SB_DONE] = 1'b1;
      c_d.sbyte[`CAQ_SB_PERR] = 1'b0;
      unique case (wr_addr)
        `CAQ_A_CTRL: begin
          // R14 halt then resume
          if (wd[`CAQ_C_HALT]) begin
            if (c_q.st == CAQ_SINGLE) begin
              c_d.st = CAQ_HALT_S;
            end else if (c_q.st == CAQ_CONT) begin
              c_d.st = CAQ_HALT_C;
            end
          end else if (wd[`CAQ_C_SINGLE]) begin
            c_d.st = CAQ_SINGLE;
          end else if (wd[`CAQ_C_REAR_TRIGGER_INPUT]) begin
            c_d.st = CAQ_REAR_TRIGGER_INPUT_WAIT;
          end else if (wd[`CAQ_C_CONT]) begin
            c_d.st = CAQ_CONT;
          end
          // R07 fast forces XY
          if (fast && !wd[`CAQ_C_HALT] && |wd[`CAQ_C_CONT:`CAQ_C_SINGLE]) begin
            c_d.sel = `CAQ_FAST_SEL;
          end
        end
        `CAQ_A_SEL: begin
          if (wd == 32'h0000_0000 ||
              (dual_mode ? |wd[31:21] : |wd[31:16])) begin
            c_d.sbyte[`CAQ_SB_PERR] = 1'b1;
          end else begin
            c_d.sel = wd[20:0];
          end
        end
        `CAQ_A_LEN: begin
          // R01 oversize refused
          if (wd == 32'h0000_0000 || |wd[31:16] ||
              !caq_fits(wd[15:0], caq_popcnt(c_q.sel))) begin
            c_d.sbyte[`CAQ_SB_PERR] = 1'b1;
          end else begin
            c_d.len = wd[15:0];
            c_d.pos = 16'h0000;
          end
        end
        `CAQ_A_INTV: begin
          if (wd > {2'h0, `CAQ_INTV_MAX}) begin
            c_d.sbyte[`CAQ_SB_PERR] = 1'b1;
          end else begin
            c_d.intv = wd[29:0];
          end
        end
        `CAQ_A_TMODE: c_d.tmode = wd[0];
        `CAQ_A_EVENT: begin
          if (wd > `CAQ_EVENT_MAX) begin
            c_d.sbyte[`CAQ_SB_PERR] = 1'b1;
          end else begin
            c_d.evt = wd[14:0];
          end
        end
        `CAQ_A_DUMP: begin
          // R19 selected curve only
          // R20 float needs sensitivity
          if (|wd[7:5] || dn > `CAQ_LAST_BIT ||
              (!dual_mode && dn > `CAQ_SINGLE_MAX) || !sel_x[dn] ||
              (wd[`CAQ_D_FLOAT] && fmask_x[dn] &&
               !c_q.sel[`CAQ_SENS_BIT])) begin
            c_d.sbyte[`CAQ_SB_PERR] = 1'b1;
          end else begin
            c_d.dact = 1'b1;
            c_d.dbase = caq_addr(caq_rank(c_q.sel, dn), c_q.len, 16'h0000);
            c_d.didx = 16'h0000;
            c_d.dready = 1'b0;
            c_d.dfetch = 1'b0;
            c_d.sbyte[`CAQ_SB_END] = 1'b0;
          end
        end
        default: c_d.sbyte[`CAQ_SB_PERR] = 1'b0;
      endcase
    end
    // R02 clamp length to share
    if (c_d.sel != c_q.sel) begin
      c_d.pos = 16'h0000;
      if (!caq_fits(c_d.len, caq_popcnt(c_d.sel))) begin
        c_d.len = 16'(`CAQ_BUF_PTS / 21'(caq_popcnt(c_d.sel)));
      end
    end
    // R22 end flag on last
    if (pop) begin
      c_d.dready = 1'b0;
      c_d.didx = c_q.didx + 16'h0001;
      if (17'(c_q.didx) + 17'h0_0001 >= 17'(c_q.len)) begin
        c_d.dact = 1'b0;
        c_d.sbyte[`CAQ_SB_END] = 1'b1;
      end
    end
    // R04 new curve reinit
    if (wr_en && wr_addr == `CAQ_A_CTRL && wd[`CAQ_C_NEW]) begin
      c_d.st = CAQ_IDLE;
      c_d.pos = 16'h0000;
      c_d.sweep = 32'h0000_0000;
      c_d.points = 32'h0000_0000;
      c_d.wbusy = 1'b0;
      c_d.dact = 1'b0;
      c_d.dready = 1'b0;
    end
    // R22 ready flag bit
    c_d.sbyte[`CAQ_SB_READY] = c_d.dready;
    // R08 fast time constant
    c_d.fast_tc = fast && (c_d.st != CAQ_IDLE) && tc_ge_5ms;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= '0;
      c_q.sel <= `CAQ_RST_SEL;
      c_q.len <= `CAQ_RST_LEN;
      c_q.intv <= `CAQ_RST_INTV;
    end else begin
      c_q <= c_d;
    end
  end

  // Buffer is not zeroed by new curve; old words just lose meaning
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    mem_rd_q <= mem[c_q.dbase + c_q.didx[14:0]];
  end

  assign s_axi_awready = x_q.awready;
  assign s_axi_wready = x_q.wready;
  assign s_axi_bvalid = x_q.bvalid;
  assign s_axi_bresp = x_q.bresp;
  assign s_axi_arready = x_q.arready;
  assign s_axi_rvalid = x_q.rvalid;
  assign s_axi_rresp = x_q.rresp;
  assign s_axi_rdata = x_q.rdata;
  assign fast_tc_640 = c_q.fast_tc;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_len_reject;
    wr_en && wr_addr == `CAQ_A_LEN &&
    !caq_fits(wd[15:0], caq_popcnt(c_q.sel))
    |=> $stable(c_q.len) && c_q.sbyte[`CAQ_SB_PERR];
  endproperty
  a_len_reject: assert property (p_len_reject) else $error("len taken"); // R01
  property p_len_fit;
    c_q.sel != 21'h0_0000 |-> caq_fits(c_q.len, caq_popcnt(c_q.sel));
  endproperty
  a_len_fit: assert property (p_len_fit) else $error("len overflow"); // R02
  property p_new;
    wr_en && wr_addr == `CAQ_A_CTRL && wd[`CAQ_C_NEW] |=>
    c_q.st == CAQ_IDLE && c_q.points == 32'h0000_0000 &&
    c_q.sweep == 32'h0000_0000;
  endproperty
  a_new: assert property (p_new) else $error("new curve left state"); // R04
  property p_fast_rate;
    strobe && fast && running |-> c_q.tick == 16'(FAST_CYC - 1);
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("fast rate"); // R06
  property p_single_stop;
    pt_done && c_q.st == CAQ_SINGLE && !wr_en && !rd_en &&
    17'(c_q.pos) + 17'h0_0001 >= 17'(c_q.len)
    |=> c_q.st == CAQ_IDLE && c_q.sweep == $past(c_q.sweep) + 32'h0000_0001;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("no stop"); // R09
  property p_rear_trigger_input_point;
    c_q.st == CAQ_REAR_TRIGGER_INPUT_WAIT && c_q.tmode && rear_trigger_input_edge && !c_q.wbusy
    |=> c_q.wbusy ##[1:21] pt_done;
  endproperty
  a_rear_trigger_input_point: assert property (p_rear_trigger_input_point) else $error("no point"); // R11
  property p_event;
    mem_we && c_q.wbit == `CAQ_EVENT_BIT |-> mem_wd == {1'b0, c_q.evt};
  endproperty
  a_event: assert property (p_event) else $error("event not stored"); // R13
  property p_halt;
    wr_en && wr_addr == `CAQ_A_CTRL && wd[`CAQ_C_HALT] &&
    !wd[`CAQ_C_NEW] && c_q.st == CAQ_CONT |=> c_q.st == CAQ_HALT_C;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored"); // R14
  property p_dump_end;
    pop && !wr_en && 17'(c_q.didx) + 17'h0_0001 >= 17'(c_q.len)
    |=> c_q.sbyte[`CAQ_SB_END] && !c_q.dact;
  endproperty
  a_dump_end: assert property (p_dump_end) else $error("dump no end"); // R22
endmodule : caq_ctrl

//--- hw/caq_pkg.sv
package caq_pkg;
  typedef enum logic [2:0] {
    CAQ_IDLE = 3'b000,
    CAQ_SINGLE = 3'b001,
    CAQ_CONT = 3'b010,
    CAQ_REAR_TRIGGER_INPUT_WAIT = 3'b011,
    CAQ_REAR_TRIGGER_INPUT_RUN = 3'b100,
    CAQ_HALT_S = 3'b101,
    CAQ_HALT_C = 3'b110
  } caq_state_t;
  typedef struct packed {
    logic [20:0][15:0] ch;
  } caq_samples_t;
  typedef struct packed {
    caq_state_t st;
    logic [20:0] sel;
    logic [15:0] len;
    logic [29:0] intv;
    logic tmode;
    logic [14:0] evt;
    logic [31:0] sweep;
    logic [31:0] points;
    logic [7:0] sbyte;
    logic [15:0] pos;
    logic [15:0] tick;
    logic [29:0] acc;
    logic wbusy;
    logic [4:0] wbit;
    logic [4:0] wslot;
    logic dact;
    logic [14:0] dbase;
    logic [15:0] didx;
    logic dready;
    logic dfetch;
    logic [15:0] ddata;
    logic fast_tc;
    caq_samples_t snap;
  } caq_ctl_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_hold;
    logic w_hold;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } caq_axi_t;
endpackage : caq_pkg

//--- hw/caq_regs.svh
`ifndef CAQ_REGS_SVH
`define CAQ_REGS_SVH
`define CAQ_A_CTRL 8'h00
`define CAQ_A_SEL 8'h04
`define CAQ_A_LEN 8'h08
`define CAQ_A_INTV 8'h0C
`define CAQ_A_TMODE 8'h10
`define CAQ_A_EVENT 8'h14
`define CAQ_A_STAT 8'h18
`define CAQ_A_SWEEP 8'h1C
`define CAQ_A_SBYTE 8'h20
`define CAQ_A_POINTS 8'h24
`define CAQ_A_DUMP 8'h28
`define CAQ_A_DDATA 8'h2C
`define CAQ_C_NEW 0
`define CAQ_C_SINGLE 1
`define CAQ_C_REAR_TRIGGER_INPUT 2
`define CAQ_C_CONT 3
`define CAQ_C_HALT 4
`define CAQ_D_FLOAT 8
`define CAQ_SB_DONE 0
`define CAQ_SB_END 1
`define CAQ_SB_PERR 2
`define CAQ_SB_READY 7
`define CAQ_RST_SEL 21'h0_0003
`define CAQ_RST_LEN 16'h0100
`define CAQ_RST_INTV 30'h0000_0005
`define CAQ_BUF_PTS 21'h0_8000
`define CAQ_INTV_MAX 30'h3B9A_CA00
`define CAQ_STEP_MS 30'h0000_0005
`define CAQ_EVENT_MAX 32'h0000_7FFF
`define CAQ_FAST_SEL 21'h0_0003
`define CAQ_FLOAT_MASK 32'h0000_0407
`define CAQ_SENS_BIT 4
`define CAQ_EVENT_BIT 5'h0D
`define CAQ_LAST_BIT 5'h14
`define CAQ_SINGLE_MAX 5'h0F
`define CAQ_CLK_NS 100
`define CAQ_TICK_US 5000
`define CAQ_FAST_US 1250
`define CAQ_TICK_CYC (`CAQ_TICK_US * 1000 / `CAQ_CLK_NS)
`define CAQ_FAST_CYC (`CAQ_FAST_US * 1000 / `CAQ_CLK_NS)
`define CAQ_RESP_OK 2'h0
`define CAQ_RESP_ERR 2'h2
`endif
